//--- src/status_pkg.sv
// Constants and state types for the event status and service request block.
// Assumes every user of it names items as status_pkg::name, with no import.
`default_nettype none

package status_pkg;

  localparam int STAT_W = 8;

  localparam int BIT_SUBPROG = 0;
  localparam int BIT_LIMIT = 1;
  localparam int BIT_SRQ_CMD = 2;
  localparam int BIT_POWER_ON = 3;
  localparam int BIT_READY = 4;
  localparam int BIT_ERROR = 5;
  localparam int BIT_SUMMARY = 6;
  localparam int BIT_DATA = 7;

  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] SVC_MASK_RST = 8'h00;
  localparam logic [7:0] ERR_MASK_RST = 8'hFF;
  localparam logic [7:0] READY_HIDE = 8'hEF;
  localparam logic [7:0] SUMMARY_EXCL = 8'hBF;
  localparam logic [7:0] LEVEL_CLEAR = 8'h80;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ALL_ZERO = 8'h00;

  typedef struct packed {
    logic [7:0] bits;
  } bank_t;

  typedef struct packed {
    logic [7:0] svc_mask;
    logic [7:0] err_mask;
    logic por;
    logic [7:0] query_data;
    logic query_valid;
    logic [7:0] poll_data;
    logic poll_valid;
  } ctrl_t;

endpackage : status_pkg

`default_nettype wire

//--- src/status_if.sv
// Carrier between the control logic and the status bit bank.
// Assumes both sides run on the same clock.
`default_nettype none

interface status_if;
  logic [7:0] set;
  logic [7:0] clear;
  logic [7:0] bits;

  modport ctrl (output set, output clear, input bits);
  modport bank (input set, input clear, output bits);
endinterface : status_if

`default_nettype wire

//--- src/status_bank.sv
// Eight sticky status bits; a set in the same cycle as a clear wins.
// Assumes set and clear come from logic on the same clock.
`default_nettype none

module status_bank (
  input wire logic clk_sys,
  input wire logic rst,
  status_if.bank sb
);

  status_pkg::bank_t state_q;
  status_pkg::bank_t state_d;
  logic [7:0] nxt;

  // Set beats clear so that no event is lost while software clears.
  for (genvar i = 0; i < status_pkg::STAT_W; i++) begin : g_bit
    assign nxt[i] = sb.set[i] | (state_q.bits[i] & ~sb.clear[i]);
  end

  always_comb begin
    state_d = state_q;
    state_d.bits = nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q.bits <= status_pkg::STATUS_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign sb.bits = state_q.bits;

endmodule : status_bank

`default_nettype wire

//--- src/status_service_request.sv
// Event status register with enable mask, summary bit and service request line.
// Assumes event inputs, commands and data come from logic on clk_sys.
//
// Notes on behaviour
// - Bit 0 sets when a stored subprogram finishes.
// - Bit 1 sets when a reading leaves the pass/fail limits.
// - Bit 2 sets when the request-service command has run.
// - Bit 3 sets once the power-on sequence has completed.
// - Bit 4 is set while the command path is idle and ready.
// - Bit 5 sets when an error is logged.
// - The error mask keeps masked error sources off bit 5.
// - Bit 6 sets when any enabled other bit is set.
// - Bit 6 stays latched after its cause goes away.
// - Bit 7 follows data waiting in the output buffer.
// - Status query returns the weighted sum and changes no bit.
// - Status query always reports bit 4 as clear.
// - Serial poll with service request asserted clears all bits but those whose cause still holds.
// - Service request line drops when bit 6 clears.
// - Serial poll without service request leaves the register alone.
// - Clear command clears all, but any bit whose cause still holds stays.
// - Service request asserts whenever an enabled bit is set.
// - Masked bits still update but never raise summary or request.
`default_nettype none

module status_service_request (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic subprog_done,
  input wire logic limit_fail,
  input wire logic srq_cmd_done,
  input wire logic cmd_idle,
  input wire logic [7:0] error_pending,
  input wire logic data_avail,
  input wire logic status_read_query,
  input wire logic serial_poll,
  input wire logic status_clear_command,
  input wire logic service_enable_mask_command,
  input wire logic error_mask_command,
  input wire logic [7:0] cmd_data,
  output logic [7:0] query_data,
  output logic query_valid,
  output logic [7:0] poll_data,
  output logic poll_valid,
  output logic service_request,
  output logic [7:0] event_status,
  output logic [7:0] service_mask,
  output logic [7:0] error_mask
);

  status_if sb ();

  status_pkg::ctrl_t state_q;
  status_pkg::ctrl_t state_d;

  logic err_cond;
  logic summary_cond;
  logic poll_clears;
  logic clear_all;
  logic [7:0] set_vec;
  logic [7:0] clear_vec;
  logic [7:0] set_core;
  logic [7:0] summary_src;

  status_bank u_bank (
    .clk_sys(clk_sys),
    .rst(rst),
    .sb(sb.bank)
  );

  // Only error sources that the mask enables can raise the error bit.
  assign err_cond = |(error_pending & state_q.err_mask);

  // A poll only clears when the request line is already asserted.
  assign poll_clears = serial_poll & sb.bits[status_pkg::BIT_SUMMARY];

  assign clear_all = status_clear_command | poll_clears;

  always_comb begin
    set_core = status_pkg::ALL_ZERO;
    set_core[status_pkg::BIT_SUBPROG] = subprog_done;
    set_core[status_pkg::BIT_LIMIT] = limit_fail;
    set_core[status_pkg::BIT_SRQ_CMD] = srq_cmd_done;
    set_core[status_pkg::BIT_POWER_ON] = state_q.por;
    set_core[status_pkg::BIT_READY] = cmd_idle;
    set_core[status_pkg::BIT_ERROR] = err_cond;
    set_core[status_pkg::BIT_DATA] = data_avail;
  end

  // The summary bit never feeds itself, so its own enable bit is ignored.
  // On a clear only the bits whose cause persists survive, so the summary looks at those.
  // Otherwise it looks at the register and so follows its cause one cycle late.
  assign summary_src = clear_all ? set_core : sb.bits;
  assign summary_cond = |(summary_src & state_q.svc_mask & status_pkg::SUMMARY_EXCL);

  always_comb begin
    set_vec = set_core;
    set_vec[status_pkg::BIT_SUMMARY] = summary_cond;
  end

  // Bit 7 is a plain level, so it is cleared every cycle and re-set while data waits.
  // Bits 4 to 6 survive a clear while their cause holds, because the set wins.
  always_comb begin
    clear_vec = status_pkg::LEVEL_CLEAR;
    if (clear_all) begin
      clear_vec = status_pkg::ALL_ONES;
    end
  end

  assign sb.set = set_vec;
  assign sb.clear = clear_vec;

  always_comb begin
    state_d = state_q;
    state_d.por = 1'b0;
    state_d.query_valid = 1'b0;
    state_d.poll_valid = 1'b0;
    if (service_enable_mask_command) begin
      state_d.svc_mask = cmd_data;
    end
    if (error_mask_command) begin
      state_d.err_mask = cmd_data;
    end
    if (status_read_query) begin
      // The block is busy with this very query, so ready always reads clear.
      state_d.query_data = sb.bits & status_pkg::READY_HIDE;
      state_d.query_valid = 1'b1;
    end
    if (serial_poll) begin
      state_d.poll_data = sb.bits;
      state_d.poll_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q.svc_mask <= status_pkg::SVC_MASK_RST;
      state_q.err_mask <= status_pkg::ERR_MASK_RST;
      state_q.por <= 1'b1;
      state_q.query_data <= status_pkg::ALL_ZERO;
      state_q.query_valid <= 1'b0;
      state_q.poll_data <= status_pkg::ALL_ZERO;
      state_q.poll_valid <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign query_data = state_q.query_data;
  assign query_valid = state_q.query_valid;
  assign poll_data = state_q.poll_data;
  assign poll_valid = state_q.poll_valid;
  assign service_request = sb.bits[status_pkg::BIT_SUMMARY];
  assign event_status = sb.bits;
  assign service_mask = state_q.svc_mask;
  assign error_mask = state_q.err_mask;

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (rst);

  logic any_event;
  assign any_event = subprog_done | limit_fail | srq_cmd_done | state_q.por;

  // Causes that are still present when a clear lands, in status bit order.
  logic [7:0] cause_vec;
  assign cause_vec = {data_avail, 1'b0, |(error_pending & error_mask), cmd_idle,
    state_q.por, srq_cmd_done, limit_fail, subprog_done};

  query_hides_ready_a: assert property (
    status_read_query |=> query_valid && !query_data[status_pkg::BIT_READY]
  ) else $error("status query showed the ready bit");

  query_value_a: assert property (
    status_read_query |=> query_data == ($past(sb.bits) & status_pkg::READY_HIDE)
  ) else $error("status query answer differs from the register");

  query_keeps_bits_a: assert property (
    (status_read_query && !clear_all) |=> (($past(sb.bits[3:0]) & ~sb.bits[3:0]) == 4'h0)
  ) else $error("status query dropped a latched bit");

  poll_clears_bits_a: assert property (
    (poll_clears && !any_event) |=> sb.bits[3:0] == 4'h0
  ) else $error("qualifying poll left event bits set");

  poll_keeps_bits_a: assert property (
    (serial_poll && !sb.bits[status_pkg::BIT_SUMMARY] && !status_clear_command)
      |=> (($past(sb.bits[3:0]) & ~sb.bits[3:0]) == 4'h0) && poll_valid
  ) else $error("poll without request changed the register");

  poll_answer_a: assert property (
    serial_poll |=> poll_data == $past(sb.bits)
  ) else $error("poll answer differs from the register");

  summary_sets_a: assert property (
    (|(sb.bits & service_mask & status_pkg::SUMMARY_EXCL) && !clear_all)
      |=> service_request ##0 sb.bits[status_pkg::BIT_SUMMARY]
  ) else $error("enabled bit did not raise the summary");

  masked_quiet_a: assert property (
    (!service_request && !(|(sb.bits & service_mask & status_pkg::SUMMARY_EXCL)) && !clear_all)
      |=> !service_request
  ) else $error("disabled bits raised the request line");

  summary_latched_a: assert property (
    (service_request && !clear_all) |=> service_request
  ) else $error("summary bit dropped without a clear");

  event_latched_a: assert property (
    (sb.bits[status_pkg::BIT_SUBPROG] && !clear_all) |=> sb.bits[status_pkg::BIT_SUBPROG] [*1]
  ) else $error("latched event bit dropped without a clear");

  power_on_a: assert property (
    $fell(rst) |-> ##1 sb.bits[status_pkg::BIT_POWER_ON]
  ) else $error("power-on bit not set after reset release");

  ready_level_a: assert property (
    cmd_idle |=> sb.bits[status_pkg::BIT_READY]
  ) else $error("ready bit not set while idle");

  error_mask_a: assert property (
    (!sb.bits[status_pkg::BIT_ERROR] && !(|(error_pending & error_mask))) |=> !sb.bits[status_pkg::BIT_ERROR]
  ) else $error("masked error set the error bit");

  data_level_a: assert property (
    sb.bits[status_pkg::BIT_DATA] == $past(data_avail)
  ) else $error("data bit does not follow the buffer");

  clear_keeps_cause_a: assert property (
    (status_clear_command && cmd_idle) |=> sb.bits[status_pkg::BIT_READY]
  ) else $error("clear removed ready while still idle");

  subprog_sets_a: assert property (
    subprog_done |=> sb.bits[status_pkg::BIT_SUBPROG]
  ) else $error("finished subprogram did not set its bit");

  limit_sets_a: assert property (
    limit_fail |=> sb.bits[status_pkg::BIT_LIMIT]
  ) else $error("limit failure did not set its bit");

  service_cmd_sets_a: assert property (
    srq_cmd_done |=> sb.bits[status_pkg::BIT_SRQ_CMD]
  ) else $error("request-service command did not set its bit");

  error_sets_a: assert property (
    (|(error_pending & error_mask)) |=> sb.bits[status_pkg::BIT_ERROR]
  ) else $error("enabled error did not set the error bit");

  data_sets_a: assert property (
    data_avail |=> sb.bits[status_pkg::BIT_DATA]
  ) else $error("waiting data did not set the data bit");

  limit_hold_a: assert property (
    (sb.bits[status_pkg::BIT_LIMIT] && !clear_all) |=> sb.bits[status_pkg::BIT_LIMIT]
  ) else $error("limit bit dropped without a clear");

  service_cmd_hold_a: assert property (
    (sb.bits[status_pkg::BIT_SRQ_CMD] && !clear_all) |=> sb.bits[status_pkg::BIT_SRQ_CMD]
  ) else $error("request-service bit dropped without a clear");

  power_on_hold_a: assert property (
    (sb.bits[status_pkg::BIT_POWER_ON] && !clear_all) |=> sb.bits[status_pkg::BIT_POWER_ON]
  ) else $error("power-on bit dropped without a clear");

  ready_hold_a: assert property (
    (sb.bits[status_pkg::BIT_READY] && !clear_all) |=> sb.bits[status_pkg::BIT_READY]
  ) else $error("ready bit dropped without a clear");

  error_hold_a: assert property (
    (sb.bits[status_pkg::BIT_ERROR] && !clear_all) |=> sb.bits[status_pkg::BIT_ERROR]
  ) else $error("error bit dropped without a clear");

  query_valid_once_a: assert property (
    !status_read_query |=> !query_valid
  ) else $error("query answer flagged without a query");

  query_data_stands_a: assert property (
    !status_read_query |=> $stable(query_data)
  ) else $error("query answer changed without a query");

  poll_valid_once_a: assert property (
    !serial_poll |=> !poll_valid
  ) else $error("poll answer flagged without a poll");

  poll_data_stands_a: assert property (
    !serial_poll |=> $stable(poll_data)
  ) else $error("poll answer changed without a poll");

  poll_shows_ready_a: assert property (
    (serial_poll && sb.bits[status_pkg::BIT_READY]) |=> poll_data[status_pkg::BIT_READY]
  ) else $error("poll answer hid the ready bit");

  poll_no_summary_a: assert property (
    (serial_poll && !service_request) |=> !poll_data[status_pkg::BIT_SUMMARY]
  ) else $error("poll without request reported a summary");

  clear_drops_request_a: assert property (
    (clear_all && !(|(cause_vec & service_mask))) |=> !service_request
  ) else $error("request line stayed with no enabled cause");

  clear_keeps_request_a: assert property (
    (clear_all && (|(cause_vec & service_mask))) |=> service_request
  ) else $error("clear dropped the request while its cause held");

  clear_keeps_error_a: assert property (
    (status_clear_command && (|(error_pending & error_mask))) |=> sb.bits[status_pkg::BIT_ERROR]
  ) else $error("clear removed the error bit while errors wait");

  clear_drops_events_a: assert property (
    (status_clear_command && !any_event) |=> sb.bits[3:0] == 4'h0
  ) else $error("clear left event bits set");

  mask_load_a: assert property (
    service_enable_mask_command |=> service_mask == $past(cmd_data)
  ) else $error("enable mask did not load");

  mask_hold_a: assert property (
    !service_enable_mask_command |=> $stable(service_mask)
  ) else $error("enable mask changed without a load");

  error_mask_load_a: assert property (
    error_mask_command |=> error_mask == $past(cmd_data)
  ) else $error("error mask did not load");

  error_mask_hold_a: assert property (
    !error_mask_command |=> $stable(error_mask)
  ) else $error("error mask changed without a load");

  cover_query_c: cover property (
    status_read_query ##1 query_valid
  );

  cover_poll_clear_c: cover property (
    poll_clears ##1 !service_request
  );

  cover_summary_c: cover property (
    !service_request ##1 service_request
  );

  cover_clear_c: cover property (
    status_clear_command && sb.bits[status_pkg::BIT_LIMIT]
  );

  cover_error_c: cover property (
    !sb.bits[status_pkg::BIT_ERROR] ##1 sb.bits[status_pkg::BIT_ERROR]
  );

endmodule : status_service_request

`default_nettype wire

//--- sim/bus_controller_model.sv
// Behavioural bus controller that issues status commands to the block.
// Assumes the bench calls send, one command at a time, on clk_sys.
`default_nettype none

module bus_controller_model (
  input wire logic clk_sys,
  output logic status_read_query,
  output logic serial_poll,
  output logic status_clear_command,
  output logic service_enable_mask_command,
  output logic error_mask_command,
  output logic [7:0] cmd_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {status_read_query, serial_poll, status_clear_command} = 3'h0;
    {service_enable_mask_command, error_mask_command} = 2'h0;
    cmd_data = 8'h00;
  end

  // Kind 0 query, 1 poll, 2 clear, 3 enable mask, 4 error mask.
  // Data is inverted after the strobe so a stale value is never taken for a load.
  task automatic send(input int kind, input logic [7:0] data);
    @(posedge clk_sys);
    #1;
    cmd_data = data;
    status_read_query = (kind == 0);
    serial_poll = (kind == 1);
    status_clear_command = (kind == 2);
    service_enable_mask_command = (kind == 3);
    error_mask_command = (kind == 4);
    @(posedge clk_sys);
    #1;
    {status_read_query, serial_poll, status_clear_command} = 3'h0;
    {service_enable_mask_command, error_mask_command} = 2'h0;
    cmd_data = ~data;
  endtask : send
endmodule : bus_controller_model

`default_nettype wire

//--- sim/status_service_request_tb.sv
// Self-checking bench for the event status and service request block.
// Assumes the controller model issues every command; events are driven here.
`default_nettype none

module status_service_request_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic subprog_done, limit_fail, srq_cmd_done, cmd_idle, data_avail;
  logic [7:0] error_pending;
  logic status_read_query, serial_poll, status_clear_command;
  logic service_enable_mask_command, error_mask_command;
  logic [7:0] cmd_data, query_data, poll_data, event_status, service_mask, error_mask;
  logic query_valid, poll_valid, service_request;
  logic [7:0] expect_q[$];
  logic [7:0] v;
  logic [7:0] seen_v;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #2 clk_sys = ~clk_sys;

  status_service_request i_status_service_request (.clk_sys(clk_sys), .rst(rst),
    .subprog_done(subprog_done), .limit_fail(limit_fail), .srq_cmd_done(srq_cmd_done),
    .cmd_idle(cmd_idle), .error_pending(error_pending), .data_avail(data_avail),
    .status_read_query(status_read_query), .serial_poll(serial_poll),
    .status_clear_command(status_clear_command), .service_enable_mask_command(service_enable_mask_command),
    .error_mask_command(error_mask_command), .cmd_data(cmd_data), .query_data(query_data),
    .query_valid(query_valid), .poll_data(poll_data), .poll_valid(poll_valid),
    .service_request(service_request), .event_status(event_status),
    .service_mask(service_mask), .error_mask(error_mask));

  bus_controller_model i_bus_controller_model (.clk_sys(clk_sys), .status_read_query(status_read_query),
    .serial_poll(serial_poll), .status_clear_command(status_clear_command),
    .service_enable_mask_command(service_enable_mask_command),
    .error_mask_command(error_mask_command), .cmd_data(cmd_data));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic st(input logic [7:0] s, input logic r);
    step(3);
    check(event_status, s);
    check({7'h00, service_request}, {7'h00, r});
  endtask : st

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // Answers stand one cycle, so they are taken at the edge after they rise.
  always @(posedge clk_sys) begin
    cycles++;
    if (query_valid === 1'b1 || poll_valid === 1'b1) begin
      seen_v = (query_valid === 1'b1) ? query_data : poll_data;
      if (expect_q.size() > 0) begin
        check(seen_v, expect_q.pop_front());
      end else begin
        check(seen_v, ~seen_v);
      end
    end
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'h667d));
    {subprog_done, limit_fail, srq_cmd_done, cmd_idle, data_avail} = 5'h00;
    error_pending = 8'h00;
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    st(8'h08, 1'b0);
    check(service_mask, 8'h00);
    check(error_mask, 8'hFF);
    cmd_idle = 1'b1;
    st(8'h18, 1'b0);
    expect_q.push_back(8'h08);
    i_bus_controller_model.send(0, 8'h00);
    expect_q.push_back(8'h18);
    i_bus_controller_model.send(1, 8'h00);
    st(8'h18, 1'b0);
    {subprog_done, limit_fail, srq_cmd_done, data_avail} = 4'hF;
    step(1);
    {subprog_done, limit_fail, srq_cmd_done} = 3'h0;
    st(8'h9F, 1'b0);
    st(8'h9F, 1'b0);
    i_bus_controller_model.send(3, 8'h02);
    st(8'hDF, 1'b1);
    expect_q.push_back(8'hDF);
    i_bus_controller_model.send(1, 8'h00);
    st(8'h90, 1'b0);
    subprog_done = 1'b1;
    step(1);
    subprog_done = 1'b0;
    st(8'h91, 1'b0);
    i_bus_controller_model.send(4, 8'hFE);
    error_pending = 8'h01;
    st(8'h91, 1'b0);
    error_pending = 8'h03;
    st(8'hB1, 1'b0);
    i_bus_controller_model.send(3, 8'h20);
    i_bus_controller_model.send(2, 8'h00);
    st(8'hF0, 1'b1);
    i_bus_controller_model.send(3, 8'h00);
    st(8'hF0, 1'b1);
    error_pending = 8'h00;
    i_bus_controller_model.send(2, 8'h00);
    st(8'h90, 1'b0);
    repeat (3) begin
      v = 8'($urandom);
      i_bus_controller_model.send(3, v);
      i_bus_controller_model.send(4, ~v);
      step(1);
      check(service_mask, v);
      check(error_mask, ~v);
    end
    step(4);
    check(8'(expect_q.size()), 8'h00);
    close_out();
  end
endmodule : status_service_request_tb

`default_nettype wire
